// ==== src/tcp_top.sv ====
// timer, capture and pwm pin control with avalon-mm register access
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
`include "tcp_defs.svh"

module tcp_top (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [3:0]  cap_pin,
	input  wire logic        shared_ext_clock_pin,
	input  wire logic        timer_c_ext_clock_pin,
	input  wire logic [2:0]  pwm_level,
	input  wire logic [1:0]  port_b_direction,
	input  wire logic        port_g_direction,
	input  wire logic [2:0]  port_latch,
	output logic      [2:0]  pwm_pin_out,
	output logic      [2:0]  pwm_pin_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// registers and state

	tcp_pkg::tcp_bus_state_type bus_state;
	tcp_pkg::tcp_bus_state_type next_bus_state;
	logic [7:0]  config_a;
	logic [7:0]  control_b;
	logic [4:0]  config_c;
	logic [4:0]  events;
	logic [7:0]  timer_a;
	logic [7:0]  timer_b;
	logic [15:0] timer_c;
	logic [7:0]  period_a;
	logic [7:0]  period_b;
	logic [15:0] cap_val [4];
	logic [3:0]  cap_ovf;
	logic [3:0]  unread;
	logic [3:0]  low_seen;
	logic [3:0]  high_seen;
	logic [3:0]  pre_cnt [4];
	logic [5:0]  sync1;
	logic [5:0]  sync2;
	logic [5:0]  prev;
	logic [7:0]  next_timer_a;
	logic [7:0]  next_timer_b;
	logic [15:0] next_timer_c;
	logic        roll;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode: one wait cycle, then the answer

	wire req       = avs_read | avs_write;
	wire done      = bus_state == tcp_pkg::TCP_BUS_RESP;
	wire wr_take   = done & avs_write;
	wire rd_take   = done & avs_read;
	wire hit_a     = avs_address == `TCP_IDX_CONFIG_A;
	wire hit_b     = avs_address == `TCP_IDX_CONTROL_B;
	wire hit_c     = avs_address == `TCP_IDX_CONFIG_C;
	wire hit_tab   = avs_address == `TCP_IDX_TIMER_AB;
	wire hit_tc    = avs_address == `TCP_IDX_TIMER_C;
	wire hit_per   = avs_address == `TCP_IDX_PERIOD_AB;
	wire hit_ev    = avs_address == `TCP_IDX_EVENTS;
	wire wr_a      = wr_take & hit_a & avs_byteenable[0];
	wire wr_b      = wr_take & hit_b & avs_byteenable[0];
	wire wr_c      = wr_take & hit_c & avs_byteenable[0];
	wire wr_per_lo = wr_take & hit_per & avs_byteenable[0];
	wire wr_per_hi = wr_take & hit_per & avs_byteenable[1];
	wire wr_ev     = wr_take & hit_ev & avs_byteenable[0];

	assign avs_waitrequest = req & ~done;
	assign next_bus_state  = (req & ~done) ? tcp_pkg::TCP_BUS_RESP : tcp_pkg::TCP_BUS_IDLE;

	// bus state and read data; read data is latched in the wait cycle so it stands
	// at the edge where waitrequest is low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_state    <= tcp_pkg::TCP_BUS_IDLE;
			avs_readdata <= 32'h00000000;
		end else begin
			bus_state <= next_bus_state;
			if (avs_read & ~done)
				avs_readdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration fields

	wire        cascade  = config_a[`TCP_A_CASCADE];
	wire        cap1_sel = control_b[`TCP_B_CAP1_SEL];
	wire        run_a    = control_b[`TCP_B_RUN_A];
	wire        run_b    = control_b[`TCP_B_RUN_B];
	wire        run_c    = control_b[`TCP_B_RUN_C];
	wire [1:0]  cap_mode [4];
	wire [3:0]  mode_wr;
	wire [3:0]  cap_en;
	wire [7:0]  reg_b_value;
	wire [7:0]  reg_c_value;

	assign cap_mode[0] = config_a[`TCP_A_CAP1_MODE_LSB +: 2];
	assign cap_mode[1] = config_a[`TCP_A_CAP2_MODE_LSB +: 2];
	assign cap_mode[2] = config_c[`TCP_C_CAP3_MODE_LSB +: 2];
	assign cap_mode[3] = config_c[`TCP_C_CAP4_MODE_LSB +: 2];
	assign mode_wr     = {wr_c, wr_c, wr_a, wr_a};
	assign cap_en      = {3'h7, cap1_sel};

	// overflow flags read back in place; config_c bit 7 reads as zero
	assign reg_b_value = {cap_ovf[1], cap_ovf[0], control_b[5:0]};
	assign reg_c_value = {1'b0, cap_ovf[3], cap_ovf[2], config_c};

	// software-written fields; overflow bits are not writable here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			config_a  <= `TCP_RST_BYTE;
			control_b <= `TCP_RST_BYTE;
			config_c  <= 5'h00;
			period_a  <= `TCP_RST_BYTE;
			period_b  <= `TCP_RST_BYTE;
		end else begin
			if (wr_a)
				config_a <= avs_writedata[7:0];
			if (wr_b)
				control_b <= avs_writedata[7:0] & `TCP_B_WR_MASK;
			if (wr_c)
				config_c <= avs_writedata[4:0];
			if (wr_per_lo)
				period_a <= avs_writedata[7:0];
			if (wr_per_hi)
				period_b <= avs_writedata[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: caps 3..0, shared clock pin 4, timer_c clock pin 5

	wire [5:0] pin_in = {timer_c_ext_clock_pin, shared_ext_clock_pin, cap_pin};
	wire [5:0] rise   = sync2 & ~prev;
	wire [5:0] fall   = prev & ~sync2;

	// sync1 feeds only sync2; edges come from sync2 against its own delayed copy
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			prev  <= 6'h00;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// capture channels

	wire [3:0] cap_event;
	wire [3:0] pair_done;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cap
			wire [7:0] my_idx = `TCP_IDX_CAP1 + 8'(gi);
			wire       rd_hit = rd_take & (avs_address == my_idx);
			wire       wr_lo  = (gi == 0) & wr_take & (avs_address == my_idx) & avs_byteenable[0];
			wire       wr_hi  = (gi == 0) & wr_take & (avs_address == my_idx) & avs_byteenable[1];
			wire       lo_now = low_seen[gi] | (rd_hit & avs_byteenable[0]);
			wire       hi_now = high_seen[gi] | (rd_hit & avs_byteenable[1]);
			wire       pre_tc4  = pre_cnt[gi][1:0] == `TCP_PRESCALE_4;
			wire       pre_tc16 = pre_cnt[gi] == `TCP_PRESCALE_16;
			logic      hit;

			// edge mode decode
			always_comb begin
				case (cap_mode[gi])
					tcp_pkg::TCP_EDGE_FALL:  hit = fall[gi];
					tcp_pkg::TCP_EDGE_RISE:  hit = rise[gi];
					tcp_pkg::TCP_EDGE_RISE4: hit = rise[gi] & pre_tc4;
					default:                 hit = rise[gi] & pre_tc16;
				endcase
			end

			assign cap_event[gi] = hit & cap_en[gi] & ~mode_wr[gi];
			assign pair_done[gi] = lo_now & hi_now;

			// prescale counter; a mode write restarts it so a stale count never fires early
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst)
					pre_cnt[gi] <= 4'h0;
				else if (mode_wr[gi])
					pre_cnt[gi] <= 4'h0;
				else if (rise[gi] & cap_en[gi])
					pre_cnt[gi] <= pre_cnt[gi] + 4'h1;
			end

			// value, unread and overflow; an event in the read-completing cycle loads
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					cap_val[gi]   <= `TCP_RST_WORD;
					unread[gi]    <= 1'b0;
					cap_ovf[gi]   <= 1'b0;
					low_seen[gi]  <= 1'b0;
					high_seen[gi] <= 1'b0;
				end else begin
					if (cap_event[gi] & unread[gi] & ~pair_done[gi]) begin
						cap_ovf[gi] <= 1'b1;
					end else if (cap_event[gi]) begin
						cap_val[gi] <= timer_c;
						unread[gi]  <= 1'b1;
						cap_ovf[gi] <= 1'b0;
					end else if (pair_done[gi]) begin
						unread[gi]  <= 1'b0;
						cap_ovf[gi] <= 1'b0;
					end
					if (wr_lo)
						cap_val[gi][7:0] <= avs_writedata[7:0];
					if (wr_hi)
						cap_val[gi][15:8] <= avs_writedata[15:8];
					low_seen[gi]  <= pair_done[gi] ? 1'b0 : lo_now;
					high_seen[gi] <= pair_done[gi] ? 1'b0 : hi_now;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// timers

	wire tick_a = config_a[`TCP_A_SRC_A] ? fall[4] : 1'b1;
	wire tick_b = config_a[`TCP_A_SRC_B] ? fall[4] : 1'b1;
	wire tick_c = config_a[`TCP_A_SRC_C] ? fall[5] : 1'b1;
	wire per_hit_c = ~cap1_sel & (timer_c == cap_val[0]);

	// timer_a / timer_b: two 8-bit counters or one 16-bit pair
	always_comb begin
		next_timer_a = timer_a;
		next_timer_b = timer_b;
		roll         = 1'b0;
		if (cascade) begin
			if (run_a & tick_a) begin
				if ({timer_b, timer_a} == {period_b, period_a}) begin
					next_timer_a = 8'h00;
					next_timer_b = 8'h00;
					roll         = 1'b1;
				end else begin
					next_timer_a = timer_a + 8'h01;
					if ((timer_a == 8'hFF) & run_b)
						next_timer_b = timer_b + 8'h01;
				end
			end
		end else begin
			if (run_a & tick_a) begin
				if (timer_a == period_a) begin
					next_timer_a = 8'h00;
					roll         = 1'b1;
				end else begin
					next_timer_a = timer_a + 8'h01;
				end
			end
			if (run_b & tick_b) begin
				if (timer_b == period_b)
					next_timer_b = 8'h00;
				else
					next_timer_b = timer_b + 8'h01;
			end
		end
	end

	// timer_c runs free in capture mode, against the cap1 value in period mode
	assign next_timer_c = (run_c & tick_c) ? (per_hit_c ? 16'h0000 : timer_c + 16'h0001)
	                                       : timer_c;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_a <= `TCP_RST_BYTE;
			timer_b <= `TCP_RST_BYTE;
			timer_c <= `TCP_RST_WORD;
		end else begin
			timer_a <= next_timer_a;
			timer_b <= next_timer_b;
			timer_c <= next_timer_c;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event flags: write one to clear, a new event wins over the clear

	wire [4:0] ev_set = {roll, cap_event};
	wire [4:0] ev_clr = wr_ev ? avs_writedata[4:0] : 5'h00;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			events <= 5'h00;
		else
			events <= (events & ~ev_clr) | ev_set;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pwm pin ownership; a set pwm enable drives the pin, otherwise direction bit high releases it

	wire [2:0] pwm_en  = {config_c[`TCP_C_PWM_C_EN], control_b[`TCP_B_PWM_B_EN],
	                      control_b[`TCP_B_PWM_A_EN]};
	wire [2:0] dir_in  = {port_g_direction, port_b_direction};
	wire [2:0] next_oe = pwm_en | ~dir_in;
	wire [2:0] next_do = (pwm_en & pwm_level) | (~pwm_en & port_latch);

	// registered so the pins never glitch on a bus write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwm_pin_out <= 3'h0;
			pwm_pin_oe  <= 3'h0;
		end else begin
			pwm_pin_out <= next_do;
			pwm_pin_oe  <= next_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_a)
			rd_mux = {24'h000000, config_a};
		else if (hit_b)
			rd_mux = {24'h000000, reg_b_value};
		else if (hit_c)
			rd_mux = {24'h000000, reg_c_value};
		else if (avs_address == `TCP_IDX_CAP1)
			rd_mux = {16'h0000, cap_val[0]};
		else if (avs_address == `TCP_IDX_CAP2)
			rd_mux = {16'h0000, cap_val[1]};
		else if (avs_address == `TCP_IDX_CAP3)
			rd_mux = {16'h0000, cap_val[2]};
		else if (avs_address == `TCP_IDX_CAP4)
			rd_mux = {16'h0000, cap_val[3]};
		else if (hit_tab)
			rd_mux = {16'h0000, timer_b, timer_a};
		else if (hit_tc)
			rd_mux = {16'h0000, timer_c};
		else if (hit_per)
			rd_mux = {16'h0000, period_b, period_a};
		else if (hit_ev)
			rd_mux = {27'h0000000, events};
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	rise_mode_a: assert property ((cap_mode[1] == 2'h1) && rise[1] && !wr_a |-> cap_event[1])
		else $error("rising edge mode missed an event");
	mode_field_a: assert property (wr_a |=> cap_mode[1] == $past(avs_writedata[7:6]))
		else $error("cap2 mode not taken from bits 7-6");
	cfgc_field_a: assert property (wr_c |=> cap_mode[2] == $past(avs_writedata[2:1]))
		else $error("cap3 mode not taken from bits 2-1");
	cascade_carry_a: assert property (cascade && run_a && run_b && tick_a && timer_a == 8'hFF
		&& {timer_b, timer_a} != {period_b, period_a}
		|=> timer_b == $past(timer_b) + 8'h01)
		else $error("cascaded carry did not reach timer_b");
	ext_tick_a: assert property (config_a[`TCP_A_SRC_C] && !fall[5] |=> timer_c == $past(timer_c))
		else $error("timer_c moved without a pin edge");
	ovf_hold_a: assert property (cap_event[1] && unread[1] && !pair_done[1]
		|=> cap_ovf[1] && cap_val[1] == $past(cap_val[1]))
		else $error("cap2 overflow lost or value replaced");
	bit7_zero_a: assert property (rd_take && hit_c |-> avs_readdata[7] == 1'b0)
		else $error("config_c bit 7 not zero");
	pwm_own_a: assert property (control_b[`TCP_B_PWM_B_EN] |=> pwm_pin_oe[1])
		else $error("pwm_b pin not driven");
	cap1_off_a: assert property (!cap1_sel |-> !cap_event[0])
		else $error("cap1 fired in period mode");
	timer_c_stop_a: assert property (!run_c |=> $stable(timer_c))
		else $error("timer_c counted while stopped");
	timer_b_stop_a: assert property (!cascade && !run_b |=> $stable(timer_b))
		else $error("timer_b counted while stopped");
	event_flag_a: assert property (cap_event[3] |=> events[3])
		else $error("capture event flag not set");
	roll_flag_a: assert property (!cascade && run_a && tick_a && timer_a == period_a
		|=> timer_a == 8'h00 && events[`TCP_EV_ROLL])
		else $error("timer_a rollover wrong");
	pin_sync_a: assert property (rise[0] |-> $past(cap_pin[0], 2) && !$past(cap_pin[0], 3))
		else $error("edge not from synchronised pin");
	pre_clear_a: assert property (wr_a |=> pre_cnt[0] == 4'h0 && pre_cnt[1] == 4'h0)
		else $error("prescale not restarted on mode write");

endmodule : tcp_top

// ==== src/tcp_defs.svh ====
// register indices, field positions, reset values and counts for the timer capture block
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// register indices: byte address on the bus is four times the index
`define TCP_IDX_CONFIG_A    8'h16
`define TCP_IDX_CONTROL_B   8'h17
`define TCP_IDX_CONFIG_C    8'h18
`define TCP_IDX_CAP1        8'h19
`define TCP_IDX_CAP2        8'h1A
`define TCP_IDX_CAP3        8'h1B
`define TCP_IDX_CAP4        8'h1C
`define TCP_IDX_TIMER_AB    8'h1D
`define TCP_IDX_TIMER_C     8'h1E
`define TCP_IDX_PERIOD_AB   8'h1F
`define TCP_IDX_EVENTS      8'h20

// timer_capture_config_a fields
`define TCP_A_CAP2_MODE_LSB 6
`define TCP_A_CAP1_MODE_LSB 4
`define TCP_A_CASCADE       3
`define TCP_A_SRC_C         2
`define TCP_A_SRC_B         1
`define TCP_A_SRC_A         0

// timer_capture_control_b fields
`define TCP_B_CAP2_OVF      7
`define TCP_B_CAP1_OVF      6
`define TCP_B_PWM_B_EN      5
`define TCP_B_PWM_A_EN      4
`define TCP_B_CAP1_SEL      3
`define TCP_B_RUN_C         2
`define TCP_B_RUN_B         1
`define TCP_B_RUN_A         0
`define TCP_B_WR_MASK       8'h3F

// capture_pwm_config_c fields
`define TCP_C_CAP4_OVF      6
`define TCP_C_CAP3_OVF      5
`define TCP_C_CAP4_MODE_LSB 3
`define TCP_C_CAP3_MODE_LSB 1
`define TCP_C_PWM_C_EN      0
`define TCP_C_WR_MASK       8'h1F

// event register: bits 3..0 capture flags, bit 4 timer_a rollover
`define TCP_EV_ROLL         4

// reset values
`define TCP_RST_BYTE        8'h00
`define TCP_RST_WORD        16'h0000

// prescale terminal counts for every 4th and every 16th rising edge
`define TCP_PRESCALE_4      4'h3
`define TCP_PRESCALE_16     4'hF

`endif

// ==== src/tcp_pkg.sv ====
// types shared by the timer capture block
package tcp_pkg;

	// capture edge mode field encodings
	typedef enum logic [1:0] {
		TCP_EDGE_FALL   = 2'h0,
		TCP_EDGE_RISE   = 2'h1,
		TCP_EDGE_RISE4  = 2'h2,
		TCP_EDGE_RISE16 = 2'h3
	} tcp_edge_type;

	// bus slave states, one-hot
	typedef enum logic [1:0] {
		TCP_BUS_IDLE = 2'b01,
		TCP_BUS_RESP = 2'b10
	} tcp_bus_state_type;

endpackage : tcp_pkg

// ==== bench/tcp_far_side.sv ====
// far-side pin model: capture inputs and external timer clock pins
`timescale 1ns/100ps

module tcp_far_side (
	input  wire logic       sys_clk,
	output logic      [5:0] pins
);
	// pins [3:0] capture channels, [4] shared clock, [5] timer_c clock; idle low
	initial pins = 6'h00;

	////////////////////////////////////////////////////////////////
	// each level is held five cycles so the two-flop synchroniser and the
	// edge detector settle before the next change or register read
	task automatic level(input int idx, input logic v);
		@(posedge sys_clk);
		pins[idx] <= v;
		repeat (5) @(posedge sys_clk);
	endtask : level

	// full pulses; clock pins stand still low once the burst ends
	task automatic pulse(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			level(idx, 1'b1);
			level(idx, 1'b0);
		end
	endtask : pulse
endmodule : tcp_far_side

// ==== bench/timer_capture_pwm_control_test.sv ====
// self-checking bench for the timer capture block over its register bus
`timescale 1ns/100ps
`include "tcp_defs.svh"

module timer_capture_pwm_control_test;
	logic        sys_clk          = 1'b0;
	logic        rst              = 1'b1;
	logic [7:0]  avs_address      = 8'h00;
	logic        avs_read         = 1'b0;
	logic        avs_write        = 1'b0;
	logic [31:0] avs_writedata    = 32'h0;
	logic [3:0]  avs_byteenable   = 4'h0;
	logic [2:0]  pwm_level        = 3'h0;
	logic [1:0]  port_b_direction = 2'h0;
	logic        port_g_direction = 1'b0;
	logic [2:0]  port_latch       = 3'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [5:0]  far_pins;
	logic [2:0]  pwm_pin_out;
	logic [2:0]  pwm_pin_oe;
	logic [31:0] rd, r1;
	logic [15:0] tv;
	logic [7:0]  oa;
	int          err_count = 0;
	int          compares  = 0;
	int          cycles    = 0;
	int          ob;
	int          obit [4]  = '{6, 7, 5, 6};
	int          pcnt [4]  = '{1, 1, 4, 16};
	logic [7:0]  ra [3]    = '{8'h16, 8'h17, 8'h18};
	logic [7:0]  rm [3]    = '{8'hFF, 8'h3F, 8'h1F};

	tcp_top u_dut (
		.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cap_pin(far_pins[3:0]),
		.shared_ext_clock_pin(far_pins[4]), .timer_c_ext_clock_pin(far_pins[5]),
		.pwm_level(pwm_level), .port_b_direction(port_b_direction),
		.port_g_direction(port_g_direction), .port_latch(port_latch),
		.pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe)
	);

	tcp_far_side u_far (.sys_clk(sys_clk), .pins(far_pins));

	// clock and a cycle ceiling well above the few thousand cycles needed
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk_reg

	task automatic chk_pin(input string nm, input logic [2:0] e, input logic [2:0] g);
		compares++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk_pin

	// one request held until waitrequest is seen low; a spare edge follows
	// so back-to-back calls never assign a strobe twice in one time step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= w;
		avs_read       <= ~w;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 4'hF);
	endtask : wr8

	task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk_reg(nm, e, rd);
	endtask : rdc

	task automatic ovf_chk(input logic [7:0] a, input int b, input logic e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk_reg("overflow", {31'h0, e}, {31'h0, rd[b]});
	endtask : ovf_chk

	////////////////////////////////////////////////////////////////
	// main sequence: reset values, pins, timers, captures
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 3; i++) begin
			rdc(ra[i], "reset value", 32'h0);
			wr8(ra[i], 8'hFF);
			rdc(ra[i], "write mask", {24'h0, rm[i]});
		end
		rdc(8'h40, "unmapped", 32'h0);
		wr8(8'h40, 8'hFF);
		rdc(8'h40, "unmapped", 32'h0);
		// all three pwm enables are on after the mask writes
		pwm_level        <= 3'h5;
		port_b_direction <= 2'h3;
		port_g_direction <= 1'b1;
		port_latch       <= 3'h2;
		repeat (3) @(posedge sys_clk);
		chk_pin("pwm out", 3'h5, pwm_pin_out);
		chk_pin("pwm oe", 3'h7, pwm_pin_oe);
		wr8(`TCP_IDX_CONFIG_C, 8'h0A);
		wr8(`TCP_IDX_CONTROL_B, 8'h0C);
		port_b_direction <= 2'h1;
		port_g_direction <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_pin("port oe", 3'h6, pwm_pin_oe);
		chk_pin("port out", 3'h2, pwm_pin_out & pwm_pin_oe);
		// timer_c on its own pin, run and stopped
		wr8(`TCP_IDX_CONFIG_A, 8'h54);
		bus(1'b0, `TCP_IDX_TIMER_C, 32'h0, 4'hF);
		tv = rd[15:0];
		u_far.pulse(5, 3);
		rdc(`TCP_IDX_TIMER_C, "timer_c", {16'h0, tv + 16'h3});
		wr8(`TCP_IDX_CONTROL_B, 8'h08);
		u_far.pulse(5, 2);
		rdc(`TCP_IDX_TIMER_C, "timer_c stop", {16'h0, tv + 16'h3});
		wr8(`TCP_IDX_CONTROL_B, 8'h0C);
		wr8(`TCP_IDX_EVENTS, 8'h1F);
		// overflow on each channel, freed by reading the two lanes apart
		for (int ch = 1; ch <= 4; ch++) begin
			oa = (ch <= 2) ? `TCP_IDX_CONTROL_B : `TCP_IDX_CONFIG_C;
			ob = obit[ch-1];
			bus(1'b0, `TCP_IDX_TIMER_C, 32'h0, 4'hF);
			tv = rd[15:0];
			u_far.pulse(ch - 1, 1);
			u_far.pulse(5, 1);
			u_far.pulse(ch - 1, 1);
			ovf_chk(oa, ob, 1'b1);
			rdc(`TCP_IDX_EVENTS, "event", 32'h1 << (ch - 1));
			bus(1'b0, 8'(`TCP_IDX_CAP1 + ch - 1), 32'h0, 4'h1);
			r1 = rd;
			ovf_chk(oa, ob, 1'b1);
			bus(1'b0, 8'(`TCP_IDX_CAP1 + ch - 1), 32'h0, 4'h2);
			chk_reg("capture", {16'h0, tv}, {16'h0, rd[15:8], r1[7:0]});
			ovf_chk(oa, ob, 1'b0);
			wr8(`TCP_IDX_EVENTS, 8'h1F);
		end
		// cap1 idle while its value is the timer_c period
		wr8(`TCP_IDX_CONTROL_B, 8'h04);
		u_far.pulse(0, 1);
		rdc(`TCP_IDX_EVENTS, "cap1 off", 32'h0);
		// every edge mode on cap2; the extra pulse leaves the prescaler mid-count
		for (int m = 0; m < 4; m++) begin
			u_far.pulse(1, 1);
			wr8(`TCP_IDX_CONFIG_A, {m[1:0], 6'h14});
			wr8(`TCP_IDX_EVENTS, 8'h1F);
			u_far.pulse(1, pcnt[m] - 1);
			rdc(`TCP_IDX_EVENTS, "early", 32'h0);
			u_far.level(1, 1'b1);
			rdc(`TCP_IDX_EVENTS, "rise", (m == 0) ? 32'h0 : 32'h2);
			u_far.level(1, 1'b0);
			rdc(`TCP_IDX_EVENTS, "fall", 32'h2);
		end
		// timer_a alone, rollover at its period, then the cascaded pair
		bus(1'b1, `TCP_IDX_PERIOD_AB, 32'hFFFF, 4'h3);
		wr8(`TCP_IDX_CONFIG_A, 8'h03);
		wr8(`TCP_IDX_CONTROL_B, 8'h01);
		wr8(`TCP_IDX_EVENTS, 8'h1F);
		bus(1'b0, `TCP_IDX_TIMER_AB, 32'h0, 4'hF);
		tv = rd[15:0];
		u_far.pulse(4, 4);
		rdc(`TCP_IDX_TIMER_AB, "timer_a", {16'h0, tv[15:8], tv[7:0] + 8'h4});
		bus(1'b1, `TCP_IDX_PERIOD_AB, {16'h0, 8'hFF, tv[7:0] + 8'h6}, 4'h3);
		wr8(`TCP_IDX_EVENTS, 8'h1F);
		u_far.pulse(4, 3);
		rdc(`TCP_IDX_TIMER_AB, "rollover", {16'h0, tv[15:8], 8'h00});
		rdc(`TCP_IDX_EVENTS, "roll flag", 32'h10);
		wr8(`TCP_IDX_EVENTS, 8'h10);
		rdc(`TCP_IDX_EVENTS, "roll clear", 32'h0);
		bus(1'b1, `TCP_IDX_PERIOD_AB, 32'hFFFF, 4'h3);
		wr8(`TCP_IDX_CONFIG_A, 8'h0B);
		wr8(`TCP_IDX_CONTROL_B, 8'h03);
		u_far.pulse(4, 260);
		rdc(`TCP_IDX_TIMER_AB, "cascade", {16'h0, tv[15:8] + 8'h1, 8'h04});
		wr8(`TCP_IDX_CONTROL_B, 8'h02);
		u_far.pulse(4, 2);
		rdc(`TCP_IDX_TIMER_AB, "pair stop", {16'h0, tv[15:8] + 8'h1, 8'h04});
		// cascaded pair rolls over at its 16-bit period and raises the same flag
		bus(1'b1, `TCP_IDX_PERIOD_AB, {16'h0, tv[15:8] + 8'h1, 8'h05}, 4'h3);
		wr8(`TCP_IDX_CONTROL_B, 8'h03);
		u_far.pulse(4, 2);
		rdc(`TCP_IDX_TIMER_AB, "pair roll", 32'h0);
		rdc(`TCP_IDX_EVENTS, "pair flag", 32'h10);
		give_verdict();
	end
endmodule : timer_capture_pwm_control_test
